// ===== src/ratio_pkg.sv
/*
  Shared constants and types for the bus/core ratio strap latch.
  Assumes a single 40 MHz reference clock domain.
*/
package ratio_pkg;

  // Reference clock period in picoseconds
  localparam int unsigned REF_PERIOD_PS = 25000;
  // Least strap setup time ahead of reset release, in microseconds
  localparam int unsigned STRAP_SETUP_US = 1000;
  // Setup time as a count of reference cycles, rounded up
  localparam int unsigned STRAP_SETUP_CYC =
    (STRAP_SETUP_US * 1000000 + REF_PERIOD_PS - 1) / REF_PERIOD_PS;

  // Strap codes that the device knows
  localparam logic [2:0] CODE_TWO_FIFTHS = 3'h0;
  localparam logic [2:0] CODE_ONE_FOURTH = 3'h4;

  // Bus/core ratio as bus cycles (den) per core cycles (num)
  typedef struct packed {
    logic [2:0] num;
    logic [1:0] den;
  } ratio_t;

  localparam ratio_t RATIO_TWO_FIFTHS = '{num: 3'h5, den: 2'h2};
  localparam ratio_t RATIO_ONE_FOURTH = '{num: 3'h4, den: 2'h1};
  localparam ratio_t RATIO_RESET = RATIO_TWO_FIFTHS;

  // Captured selection together with its qualifiers
  typedef struct packed {
    logic [2:0] code;
    logic valid;
    logic reserved;
  } select_t;

  localparam select_t SELECT_RESET = '{code: 3'h0, valid: 1'b0, reserved: 1'b0};

  // Width of the core tick credit counter
  localparam int unsigned CREDIT_W = 4;

  // Sequencing states, one-hot
  typedef enum logic [2:0] {
    ST_WAIT_POR = 3'h1,
    ST_HELD = 3'h2,
    ST_RUN = 3'h4
  } seq_state_t;

endpackage

// ===== src/core_clock_gen.sv
/*
  Core tick generator: turns each bus clock edge into num/den core ticks.
  Assumes busEdge pulses are at least four reference cycles apart.
*/
`timescale 1ns/1ps
module core_clock_gen (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic enable,
  input wire logic busEdge,
  input wire ratio_pkg::ratio_t ratio,
  output logic coreTick
);

  logic [ratio_pkg::CREDIT_W-1:0] credit;
  logic [ratio_pkg::CREDIT_W-1:0] next_credit;
  logic canTick;

  ////////////////////////////////////////////////////////////////////////
  // Credit bookkeeping: each bus edge adds num, each core tick spends den
  assign canTick = enable && (credit >= ratio_pkg::CREDIT_W'(ratio.den));

  always_comb
  begin
    next_credit = credit;
    if (canTick)
    begin
      next_credit = next_credit - ratio_pkg::CREDIT_W'(ratio.den);
    end
    if (enable && busEdge)
    begin
      next_credit = next_credit + ratio_pkg::CREDIT_W'(ratio.num);
    end
  end

  // Credit drops to zero while disabled so restart is phase clean
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || !enable)
    begin
      credit <= '0;
    end
    else
    begin
      credit <= next_credit;
    end
  end

  // Registered tick keeps the data-style output glitch free
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      coreTick <= 1'b0;
    end
    else
    begin
      coreTick <= canTick;
    end
  end

endmodule

// ===== src/bus_core_ratio_strap_latch.sv
/*
  Bus/core ratio strap latch: captures the bus fraction straps when the
  device reset pin falls with the power-on pin high and drives the core tick generator.
  Assumes strap, reset, power-on and bus clock pins are asynchronous to
  ref_clk and are sampled through two flip-flops here.
*/
// Summary of operation
// - Straps are captured as reset falls; captured code picks the ratio.
// - Code 000 gives ratio 2/5; code 100 gives ratio 1/4.
// - Warm reset keeps the ratio; only power-on reset re-captures.
// - Core clock is the bus clock times the reciprocal of the ratio.
`timescale 1ns/1ps
module bus_core_ratio_strap_latch #(
  parameter int unsigned SETUP_CYCLES = ratio_pkg::STRAP_SETUP_CYC
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [2:0] bus_fraction_strap,
  input wire logic resetPin,
  input wire logic powerOnPin,
  input wire logic busClkPin,
  output ratio_pkg::ratio_t ratio_select,
  output logic ratioValid,
  output logic strapReserved,
  output logic setupViolation,
  output logic strapChanged,
  output logic coreTick
);

  logic [2:0] strapMeta;
  logic [2:0] strapSync;
  logic [2:0] pinMeta;
  logic [2:0] pinSync;
  logic resetPrev;
  logic busPrev;
  logic resetFall;
  logic busEdge;
  logic [2:0] strapPrev;
  logic [31:0] stableCount;
  ratio_pkg::select_t sel;
  ratio_pkg::seq_state_t state;
  ratio_pkg::seq_state_t next_state;
  logic captureNow;

  ////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for every pin
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      strapMeta <= 3'h0;
      strapSync <= 3'h0;
      pinMeta <= 3'h0;
      pinSync <= 3'h0;
    end
    else
    begin
      strapMeta <= bus_fraction_strap;
      strapSync <= strapMeta;
      pinMeta <= {busClkPin, powerOnPin, resetPin};
      pinSync <= pinMeta;
    end
  end

  // Edge history of synchronised reset and bus clock
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      resetPrev <= 1'b0;
      busPrev <= 1'b0;
      strapPrev <= 3'h0;
    end
    else
    begin
      resetPrev <= pinSync[0];
      busPrev <= pinSync[2];
      strapPrev <= strapSync;
    end
  end

  assign resetFall = resetPrev && !pinSync[0];
  assign busEdge = !busPrev && pinSync[2];

  ////////////////////////////////////////////////////////////////////////
  // Sequencer: wait for power-on, hold in reset, run
  always_comb
  begin
    next_state = state;
    case (state)
      ratio_pkg::ST_WAIT_POR:
      begin
        if (pinSync[0] && pinSync[1])
        begin
          next_state = ratio_pkg::ST_HELD;
        end
      end
      ratio_pkg::ST_HELD:
      begin
        if (resetFall)
        begin
          next_state = ratio_pkg::ST_RUN;
        end
      end
      ratio_pkg::ST_RUN:
      begin
        if (pinSync[0] && pinSync[1])
        begin
          next_state = ratio_pkg::ST_HELD;
        end
      end
      default:
      begin
        next_state = ratio_pkg::ST_WAIT_POR;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state <= ratio_pkg::ST_WAIT_POR;
    end
    else
    begin
      state <= next_state;
    end
  end

  // power-on qualified load; warm reset leaves the latch alone
  assign captureNow = resetFall && pinSync[1] && (state == ratio_pkg::ST_HELD);

  ////////////////////////////////////////////////////////////////////////
  // Ratio latch; reserved codes fall back to the slower ratio
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      sel <= ratio_pkg::SELECT_RESET;
    end
    else if (captureNow)
    begin
      sel.code <= strapSync;
      sel.valid <= 1'b1;
      sel.reserved <= (strapSync != ratio_pkg::CODE_TWO_FIFTHS) &&
                      (strapSync != ratio_pkg::CODE_ONE_FOURTH);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      ratio_select <= ratio_pkg::RATIO_RESET;
    end
    else if (captureNow)
    begin
      if (strapSync == ratio_pkg::CODE_ONE_FOURTH)
      begin
        ratio_select <= ratio_pkg::RATIO_ONE_FOURTH;
      end
      else
      begin
        ratio_select <= ratio_pkg::RATIO_TWO_FIFTHS;
      end
    end
  end

  assign ratioValid = sel.valid;
  assign strapReserved = sel.reserved;

  ////////////////////////////////////////////////////////////////////////
  // Board behaviour monitors; sticky until sys_rst
  // Saturating count of cycles the straps have stood still
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || (strapSync != strapPrev))
    begin
      stableCount <= 32'h0;
    end
    else if (stableCount != 32'hffffffff)
    begin
      stableCount <= stableCount + 32'h1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      setupViolation <= 1'b0;
      strapChanged <= 1'b0;
    end
    else
    begin
      if (captureNow && (stableCount < SETUP_CYCLES))
      begin
        setupViolation <= 1'b1;
      end
      if (pinSync[0] && resetPrev && (strapSync != strapPrev))
      begin
        strapChanged <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // core ticks scaled by the latched ratio
  core_clock_gen u_core_clock_gen (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .enable(sel.valid && (state == ratio_pkg::ST_RUN)),
    .busEdge(busEdge),
    .ratio(ratio_select),
    .coreTick(coreTick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks
  property p_capture;
    @(posedge ref_clk) disable iff (sys_rst)
    captureNow |=> ratioValid && (sel.code == $past(strapSync));
  endproperty
  a_capture: assert property (p_capture) else $error("strap not captured");

  property p_decode;
    @(posedge ref_clk) disable iff (sys_rst)
    captureNow && (strapSync == ratio_pkg::CODE_ONE_FOURTH)
      |=> ratio_select == ratio_pkg::RATIO_ONE_FOURTH;
  endproperty
  a_decode: assert property (p_decode) else $error("wrong ratio for code 100");

  property p_warm;
    @(posedge ref_clk) disable iff (sys_rst)
    resetFall && !pinSync[1] |=> $stable(ratio_select) && $stable(sel);
  endproperty
  a_warm: assert property (p_warm) else $error("warm reset changed ratio");

  property p_tick;
    @(posedge ref_clk) disable iff (sys_rst)
    !(sel.valid && state == ratio_pkg::ST_RUN) ##1
      !(sel.valid && state == ratio_pkg::ST_RUN) |-> !coreTick;
  endproperty
  a_tick: assert property (p_tick) else $error("core tick while stopped");

  property p_latch;
    @(posedge ref_clk) disable iff (sys_rst)
    !captureNow |=> $stable(ratio_select);
  endproperty
  a_latch: assert property (p_latch) else $error("ratio changed without capture");

  c_quarter: cover property (@(posedge ref_clk) disable iff (sys_rst)
    captureNow && strapSync == ratio_pkg::CODE_ONE_FOURTH);
  c_warm: cover property (@(posedge ref_clk) disable iff (sys_rst)
    ratioValid && resetFall && !pinSync[1]);
  c_ticks: cover property (@(posedge ref_clk) disable iff (sys_rst)
    coreTick ##1 coreTick);

endmodule

// ===== verification/board_model.sv
/*
  Board strapping and system reset model for the ratio strap latch.
  Assumes the bench calls its tasks from one thread, after sys_rst is released.
*/
`timescale 1ns/1ps
module board_model (
  input wire logic ref_clk,
  output logic [2:0] strap,
  output logic resetPin,
  output logic powerOnPin,
  output logic busClkPin
);
  // Pins idle low from time zero
  initial
  begin
    strap = 3'h0;
    resetPin = 1'b0;
    powerOnPin = 1'b0;
    busClkPin = 1'b0;
  end

  ////////////////////
  // code only as commanded
  task automatic reset_pulse(input logic [2:0] code, input logic por);
    @(posedge ref_clk);
    #1;
    // straps set before reset, steady throughout
    strap = code;
    powerOnPin = por;
    resetPin = 1'b1;
    repeat (30) @(posedge ref_clk);
    #1 resetPin = 1'b0;
    repeat (8) @(posedge ref_clk);
    #1 powerOnPin = 1'b0;
  endtask

  // Straps move late in reset, breaking setup on purpose; they then hold steady after reset falls
  task automatic reset_moving(input logic [2:0] first, input logic [2:0] last);
    @(posedge ref_clk);
    #1;
    strap = first;
    powerOnPin = 1'b1;
    resetPin = 1'b1;
    repeat (25) @(posedge ref_clk);
    #1 strap = last;
    repeat (5) @(posedge ref_clk);
    #1 resetPin = 1'b0;
    repeat (8) @(posedge ref_clk);
    #1 powerOnPin = 1'b0;
  endtask

  // fixed bus period, ten reference cycles
  task automatic bus_edges(input int n);
    repeat (n)
    begin
      @(posedge ref_clk);
      #1 busClkPin = 1'b1;
      repeat (5) @(posedge ref_clk);
      #1 busClkPin = 1'b0;
      repeat (4) @(posedge ref_clk);
    end
  endtask
endmodule

// ===== verification/bus_core_ratio_strap_latch_test.sv
/*
  Self-checking bench for the ratio strap latch.
  Assumes board_model drives every pin; setup count shortened to 20 cycles.
*/
`timescale 1ns/1ps
module bus_core_ratio_strap_latch_test;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] strap;
  logic resetPin;
  logic powerOnPin;
  logic busClkPin;
  ratio_pkg::ratio_t ratio_select;
  logic ratioValid;
  logic strapReserved;
  logic setupViolation;
  logic strapChanged;
  logic coreTick;
  int n_mismatch = 0;
  int comparisons = 0;
  int ticks = 0;

  // 40 MHz reference
  always #12.5 ref_clk = ~ref_clk;

  // Tick counter; case equality keeps unknowns out
  always @(posedge ref_clk)
    if (coreTick === 1'b1)
      ticks <= ticks + 1;

  bus_core_ratio_strap_latch #(.SETUP_CYCLES(20)) dut (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .bus_fraction_strap(strap),
    .resetPin(resetPin),
    .powerOnPin(powerOnPin),
    .busClkPin(busClkPin),
    .ratio_select(ratio_select),
    .ratioValid(ratioValid),
    .strapReserved(strapReserved),
    .setupViolation(setupViolation),
    .strapChanged(strapChanged),
    .coreTick(coreTick)
  );

  board_model board (
    .ref_clk(ref_clk),
    .strap(strap),
    .resetPin(resetPin),
    .powerOnPin(powerOnPin),
    .busClkPin(busClkPin)
  );

  ////////////////////
  task automatic report_and_stop();
    $display("mismatches %0d, comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Latched state and monitor flags, then ticks over a burst of bus edges
  // Tick count is taken as a difference so only the counter process writes it
  task automatic expect_run(input ratio_pkg::ratio_t r, input logic rsv, input logic flg,
    input int n);
    int want;
    int start;
    want = n * int'(r.num) / int'(r.den);
    comparisons++;
    if (ratio_select !== r || ratioValid !== 1'b1 || strapReserved !== rsv)
    begin
      $display("MISMATCH %0t latched ratio or flags", $time);
      n_mismatch++;
    end
    comparisons++;
    if (setupViolation !== flg || strapChanged !== flg)
    begin
      $display("MISMATCH %0t board monitor flags", $time);
      n_mismatch++;
    end
    start = ticks;
    board.bus_edges(n);
    repeat (8) @(posedge ref_clk);
    comparisons++;
    if (ticks - start != want)
    begin
      $display("MISMATCH %0t core ticks %0d, wanted %0d", $time, ticks - start, want);
      n_mismatch++;
    end
  endtask

  ////////////////////
  task automatic s_por_two_fifths();
    int i;
    // Latch empty after sys_rst, ratio at its reset value
    comparisons++;
    if (ratioValid !== 1'b0 || ratio_select !== ratio_pkg::RATIO_RESET)
    begin
      $display("MISMATCH %0t latch not empty after reset", $time);
      n_mismatch++;
    end
    board.reset_pulse(3'h0, 1'b1);
    // Bounded wait; a capture that never lands ends the run
    for (i = 0; i < 20 && ratioValid !== 1'b1; i++)
      @(posedge ref_clk);
    if (ratioValid !== 1'b1)
    begin
      $display("MISMATCH %0t no capture", $time);
      n_mismatch++;
      report_and_stop();
    end
    expect_run(ratio_pkg::RATIO_TWO_FIFTHS, 1'b0, 1'b0, 4);
  endtask

  task automatic s_por_one_fourth();
    board.reset_pulse(3'h4, 1'b1);
    expect_run(ratio_pkg::RATIO_ONE_FOURTH, 1'b0, 1'b0, 4);
  endtask

  // Warm reset with other straps must not re-capture
  task automatic s_warm_keeps();
    board.reset_pulse(3'h0, 1'b0);
    expect_run(ratio_pkg::RATIO_ONE_FOURTH, 1'b0, 1'b0, 2);
  endtask

  // Reserved code falls back to 2/5 and flags it
  task automatic s_reserved();
    board.reset_pulse(3'h3, 1'b1);
    expect_run(ratio_pkg::RATIO_TWO_FIFTHS, 1'b1, 1'b0, 2);
  endtask

  // Straps move late in reset; both sticky monitors must trip, so this runs last
  task automatic s_strap_moves();
    board.reset_moving(3'h0, 3'h4);
    expect_run(ratio_pkg::RATIO_ONE_FOURTH, 1'b0, 1'b1, 2);
  endtask

  ////////////////////
  // Main sequence
  initial
  begin
    repeat (16) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    repeat (2) @(posedge ref_clk);
    s_por_two_fifths();
    s_por_one_fourth();
    s_warm_keeps();
    s_reserved();
    s_strap_moves();
    report_and_stop();
  end
endmodule
